// ---- hdl/rpsel_top.sv ----
`include "rpsel_consts.svh"
module rpsel_top
  import rpsel_pkg::*;
#(
  parameter int NUM_PINS = 64,
  parameter int NUM_FUNCS = 64,
  parameter bit REDUCED_PINS = 1'b0
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // Register port
  input wire logic [2:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [15:0] REG_RDATA,
  // Pins and peripherals
  input wire logic [NUM_PINS-1:0] REMAPPABLE_PIN,
  input wire logic [NUM_FUNCS-1:0] PERIPH_OUT_FUNC,
  output rpsel_pin_in_t PERIPH_IN,
  output logic [7:0] PIN_OUT
);

  localparam int FW = `RPSEL_FLD_W;

  // Selection fields
  rpsel_fld_t lc_b_ff, lc_a_ff, u4_cts_ff, u4_rx_ff;
  rpsel_fld_t s3_clk_ff, s3_dat_ff, s3_ss_ff;
  rpsel_fld_t nxt_lc_b, nxt_lc_a, nxt_u4_cts, nxt_u4_rx;
  rpsel_fld_t nxt_s3_clk, nxt_s3_dat, nxt_s3_ss;
  rpsel_fld_t map_ff [8];
  rpsel_fld_t nxt_map [8];
  logic [15:0] rdata_ff, nxt_rdata;

  // Pin synchronisers; stage one feeds only stage two
  logic [NUM_PINS-1:0] pin_s1_ff, pin_s2_ff;
  logic [NUM_FUNCS-1:0] fn_s1_ff, fn_s2_ff;
  rpsel_pin_in_t pin_in_ff, nxt_pin_in;
  logic [7:0] pin_out_ff, nxt_pin_out;

  rpsel_fld_t w_hi, w_lo;
  assign w_hi = REG_WDATA[`RPSEL_HI_LSB +: FW];
  assign w_lo = REG_WDATA[`RPSEL_LO_LSB +: FW];

  function automatic logic [15:0] pack2(rpsel_fld_t hi, rpsel_fld_t lo);
    pack2 = {2'h0, hi, 2'h0, lo};
  endfunction

  function automatic logic pick_pin(logic [NUM_PINS-1:0] v,
                                    rpsel_fld_t s);
    logic r;
    r = 1'b0;
    if (int'(s) < NUM_PINS) begin
      r = v[s];
    end
    pick_pin = r;
  endfunction

  function automatic logic pick_fn(logic [NUM_FUNCS-1:0] v,
                                   rpsel_fld_t s);
    logic r;
    r = 1'b0;
    if (int'(s) < NUM_FUNCS) begin
      r = v[s];
    end
    pick_fn = r;
  endfunction

  // Register writes and read data
  always_comb begin
    nxt_lc_b = lc_b_ff;
    nxt_lc_a = lc_a_ff;
    nxt_u4_cts = u4_cts_ff;
    nxt_u4_rx = u4_rx_ff;
    nxt_s3_clk = s3_clk_ff;
    nxt_s3_dat = s3_dat_ff;
    nxt_s3_ss = s3_ss_ff;
    for (int i = 0; i < 8; i++) begin
      nxt_map[i] = map_ff[i];
    end
    if (REG_WR) begin
      case (REG_ADDR)
        `RPSEL_IDX_LC_IN: begin
          nxt_lc_b = w_hi;
          nxt_lc_a = w_lo;
        end
        `RPSEL_IDX_U4_IN: begin
          nxt_u4_cts = w_hi;
          nxt_u4_rx = w_lo;
        end
        `RPSEL_IDX_S3_CD: begin
          nxt_s3_clk = w_hi;
          nxt_s3_dat = w_lo;
        end
        `RPSEL_IDX_S3_SS: begin
          nxt_s3_ss = w_lo;
        end
        `RPSEL_IDX_MAP01: begin
          nxt_map[1] = w_hi;
          nxt_map[0] = w_lo;
        end
        `RPSEL_IDX_MAP23: begin
          nxt_map[3] = w_hi;
          nxt_map[2] = w_lo;
        end
        `RPSEL_IDX_MAP45: begin
          // Pin five field does not exist on reduced variants
          if (!REDUCED_PINS) begin
            nxt_map[5] = w_hi;
          end
          nxt_map[4] = w_lo;
        end
        `RPSEL_IDX_MAP67: begin
          nxt_map[7] = w_hi;
          nxt_map[6] = w_lo;
        end
        default: begin
        end
      endcase
    end
    nxt_rdata = 16'h0000;
    if (REG_RD) begin
      case (REG_ADDR)
        `RPSEL_IDX_LC_IN: nxt_rdata = pack2(lc_b_ff, lc_a_ff);
        `RPSEL_IDX_U4_IN: nxt_rdata = pack2(u4_cts_ff, u4_rx_ff);
        `RPSEL_IDX_S3_CD: nxt_rdata = pack2(s3_clk_ff, s3_dat_ff);
        `RPSEL_IDX_S3_SS: nxt_rdata = pack2(6'h00, s3_ss_ff);
        `RPSEL_IDX_MAP01: nxt_rdata = pack2(map_ff[1], map_ff[0]);
        `RPSEL_IDX_MAP23: nxt_rdata = pack2(map_ff[3], map_ff[2]);
        `RPSEL_IDX_MAP45: nxt_rdata = pack2(map_ff[5], map_ff[4]);
        `RPSEL_IDX_MAP67: nxt_rdata = pack2(map_ff[7], map_ff[6]);
        default: nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lc_b_ff <= `RPSEL_IN_RST;
      lc_a_ff <= `RPSEL_IN_RST;
      u4_cts_ff <= `RPSEL_IN_RST;
      u4_rx_ff <= `RPSEL_IN_RST;
      s3_clk_ff <= `RPSEL_IN_RST;
      s3_dat_ff <= `RPSEL_IN_RST;
      s3_ss_ff <= `RPSEL_IN_RST;
      for (int i = 0; i < 8; i++) begin
        map_ff[i] <= `RPSEL_OUT_RST;
      end
      rdata_ff <= 16'h0000;
    end else begin
      lc_b_ff <= nxt_lc_b;
      lc_a_ff <= nxt_lc_a;
      u4_cts_ff <= nxt_u4_cts;
      u4_rx_ff <= nxt_u4_rx;
      s3_clk_ff <= nxt_s3_clk;
      s3_dat_ff <= nxt_s3_dat;
      s3_ss_ff <= nxt_s3_ss;
      for (int i = 0; i < 8; i++) begin
        map_ff[i] <= nxt_map[i];
      end
      rdata_ff <= nxt_rdata;
    end
  end

  // Routing muxes read the registered fields, so a write takes effect
  // in one clean step with no half-updated select.
  always_comb begin
    nxt_pin_in.logic_cell_ext_input_b = pick_pin(pin_s2_ff, lc_b_ff);
    nxt_pin_in.logic_cell_ext_input_a = pick_pin(pin_s2_ff, lc_a_ff);
    nxt_pin_in.uart_four_clear_to_send = pick_pin(pin_s2_ff, u4_cts_ff);
    nxt_pin_in.uart_four_receive = pick_pin(pin_s2_ff, u4_rx_ff);
    nxt_pin_in.spi_three_clock_in = pick_pin(pin_s2_ff, s3_clk_ff);
    nxt_pin_in.spi_three_data_in = pick_pin(pin_s2_ff, s3_dat_ff);
    nxt_pin_in.spi_three_select_in = pick_pin(pin_s2_ff, s3_ss_ff);
    for (int i = 0; i < 8; i++) begin
      nxt_pin_out[i] = pick_fn(fn_s2_ff, map_ff[i]);
    end
    if (REDUCED_PINS) begin
      nxt_pin_out[5] = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
      fn_s1_ff <= '0;
      fn_s2_ff <= '0;
      pin_in_ff <= '0;
      pin_out_ff <= 8'h00;
    end else begin
      pin_s1_ff <= REMAPPABLE_PIN;
      pin_s2_ff <= pin_s1_ff;
      fn_s1_ff <= PERIPH_OUT_FUNC;
      fn_s2_ff <= fn_s1_ff;
      pin_in_ff <= nxt_pin_in;
      pin_out_ff <= nxt_pin_out;
    end
  end

  assign REG_RDATA = rdata_ff;
  assign PERIPH_IN = pin_in_ff;
  assign PIN_OUT = pin_out_ff;

endmodule // rpsel_top

// ---- include/rpsel_consts.svh ----
`ifndef RPSEL_CONSTS_SVH
`define RPSEL_CONSTS_SVH
// Register indices on the plain register port
`define RPSEL_IDX_LC_IN 3'h0
`define RPSEL_IDX_U4_IN 3'h1
`define RPSEL_IDX_S3_CD 3'h2
`define RPSEL_IDX_S3_SS 3'h3
`define RPSEL_IDX_MAP01 3'h4
`define RPSEL_IDX_MAP23 3'h5
`define RPSEL_IDX_MAP45 3'h6
`define RPSEL_IDX_MAP67 3'h7
// Field positions
`define RPSEL_HI_LSB 8
`define RPSEL_LO_LSB 0
`define RPSEL_FLD_W 6
// Reset values of one field
`define RPSEL_IN_RST 6'h3F
`define RPSEL_OUT_RST 6'h00
`endif

// ---- include/rpsel_pkg.sv ----
package rpsel_pkg;
  typedef logic [5:0] rpsel_fld_t;
  // Peripheral inputs fed from the pins
  typedef struct packed {
    logic logic_cell_ext_input_b;
    logic logic_cell_ext_input_a;
    logic uart_four_clear_to_send;
    logic uart_four_receive;
    logic spi_three_clock_in;
    logic spi_three_data_in;
    logic spi_three_select_in;
  } rpsel_pin_in_t;
endpackage

// ---- verif/rpsel_far.sv ----
module rpsel_far #(
  parameter int N = 64
) (
  input wire logic fill,
  input wire logic [6:0] sel,
  output logic [N-1:0] pins,
  output logic [N-1:0] funcs
);
  // One-hot shows which source a route took; sel past N drives all low
  assign pins = fill ? '1 : {{(N-1){1'h0}}, 1'h1} << sel;
  assign funcs = pins;
endmodule // rpsel_far

// ---- verif/rpsel_top_assertions.sv ----
module rpsel_chk
  import rpsel_pkg::*;
#(
  parameter int NUM_PINS = 64,
  parameter int NUM_FUNCS = 64
) (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [2:0] REG_ADDR,
  input wire logic REG_RD,
  input wire logic [15:0] REG_RDATA,
  input wire logic [NUM_PINS-1:0] REMAPPABLE_PIN,
  input wire logic [NUM_FUNCS-1:0] PERIPH_OUT_FUNC,
  input wire rpsel_pin_in_t PERIPH_IN,
  input wire logic [7:0] PIN_OUT
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  a_rd_idle_zero: assert property (
    !$past(REG_RD) |-> REG_RDATA == 16'h0000) else $error("stray rdata");
  a_spare_bits_zero: assert property (
    REG_RDATA[15:14] == 2'h0 && REG_RDATA[7:6] == 2'h0)
    else $error("spare bits set");
  a_select_hi_zero: assert property (
    $past(REG_RD) && $past(REG_ADDR) == 3'h3 |-> REG_RDATA[15:6] == 10'h000)
    else $error("select reg high bits set");
  a_reread_same: assert property (
    REG_RD ##1 (REG_RD && $stable(REG_ADDR)) |=> $stable(REG_RDATA))
    else $error("reread differs");
  // Four stable samples cover the two-flop synchroniser plus output stage
  a_in_all_high: assert property (
    $stable(REMAPPABLE_PIN)[*4] ##0 (&REMAPPABLE_PIN) |-> PERIPH_IN == 7'h7F)
    else $error("inputs not high");
  a_in_all_low: assert property (
    $stable(REMAPPABLE_PIN)[*4] ##0 (REMAPPABLE_PIN == '0)
    |-> PERIPH_IN == 7'h00) else $error("inputs not low");
  a_out_all_high: assert property (
    $stable(PERIPH_OUT_FUNC)[*4] ##0 (&PERIPH_OUT_FUNC) |-> PIN_OUT == 8'hFF)
    else $error("pins not high");
  a_out_all_low: assert property (
    $stable(PERIPH_OUT_FUNC)[*4] ##0 (PERIPH_OUT_FUNC == '0)
    |-> PIN_OUT == 8'h00) else $error("pins not low");
endmodule // rpsel_chk
bind rpsel_top rpsel_chk #(.NUM_PINS(NUM_PINS), .NUM_FUNCS(NUM_FUNCS)) chk (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .REMAPPABLE_PIN(REMAPPABLE_PIN),
  .PERIPH_OUT_FUNC(PERIPH_OUT_FUNC), .PERIPH_IN(PERIPH_IN), .PIN_OUT(PIN_OUT)
);

// ---- verif/rpsel_top_test.sv ----
module rpsel_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic fill = 1'h0;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [6:0] sel = 7'h40;
  logic [63:0] pins, funcs;
  rpsel_pkg::rpsel_pin_in_t periph_in;
  logic [7:0] pin_out;
  // Second copy built as the reduced-pin variant
  logic [15:0] rdata_red;
  rpsel_pkg::rpsel_pin_in_t periph_in_red;
  logic [7:0] pin_out_red;
  int n_errors = 0, check_count = 0, cyc = 0;
  rpsel_top uut (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata), .REMAPPABLE_PIN(pins),
    .PERIPH_OUT_FUNC(funcs), .PERIPH_IN(periph_in), .PIN_OUT(pin_out)
  );
  rpsel_top #(.REDUCED_PINS(1'b1)) uut_red (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(rdata_red), .REMAPPABLE_PIN(pins),
    .PERIPH_OUT_FUNC(funcs), .PERIPH_IN(periph_in_red),
    .PIN_OUT(pin_out_red)
  );
  rpsel_far far (.fill(fill), .sel(sel), .pins(pins), .funcs(funcs));
  initial forever #25 sys_clk = ~sys_clk;
  task automatic close_out;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'h1;
    reg_rd <= 1'h0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'h0;
  endtask
  // Strobe drops after its one sampled edge
  task automatic rd(logic [2:0] a, logic [15:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_wr <= 1'h0;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 chk("rdata", exp, reg_rdata);
  endtask
  task automatic settle(logic f, logic [6:0] s);
    @(posedge sys_clk);
    reg_rd <= 1'h0;
    reg_wr <= 1'h0;
    fill <= f;
    sel <= s;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_reset;
    for (int i = 0; i < 8; i++)
      rd(3'(i), i < 3 ? 16'h3F3F : i == 3 ? 16'h003F : 16'h0000);
    rd(3'h7, 16'h0000);
    // Two reads of one register back to back
    @(posedge sys_clk);
    reg_rd <= 1'h1;
    reg_addr <= 3'h1;
    repeat (2) @(posedge sys_clk);
    reg_rd <= 1'h0;
    #1 chk("rdata", 16'h3F3F, reg_rdata);
    $display("t_reset done");
  endtask
  task automatic t_regs;
    for (int i = 0; i < 8; i++) begin
      wr(3'(i), 16'hD5EA);
      rd(3'(i), i == 3 ? 16'h002A : 16'h152A);
      chk("rdata_red", i == 3 || i == 6 ? 16'h002A : 16'h152A, rdata_red);
    end
    $display("t_regs done");
  endtask
  task automatic t_route_in;
    wr(3'h0, 16'h0102);
    wr(3'h1, 16'h0304);
    wr(3'h2, 16'h0506);
    wr(3'h3, 16'h0007);
    for (int k = 1; k < 8; k++) begin
      settle(1'h0, 7'(k));
      chk("periph_in", 16'(8'h80 >> k), {9'h000, periph_in});
    end
    wr(3'h0, 16'h0107);
    settle(1'h0, 7'h07);
    chk("periph_in", 16'h0021, {9'h000, periph_in});
    $display("t_route_in done");
  endtask
  task automatic t_route_out;
    for (int i = 0; i < 4; i++)
      wr(3'(4 + i), {8'(9 + 2 * i), 8'(8 + 2 * i)});
    for (int k = 0; k < 8; k++) begin
      settle(1'h0, 7'(8 + k));
      chk("pin_out", 16'(8'h01 << k), {8'h00, pin_out});
      chk("pin_out_red", k == 5 ? 16'h0000 : 16'(8'h01 << k),
          {8'h00, pin_out_red});
    end
    settle(1'h1, 7'h40);
    chk("pin_out", 16'h00FF, {8'h00, pin_out});
    chk("pin_out_red", 16'h00DF, {8'h00, pin_out_red});
    chk("periph_in_red", 16'h007F, {9'h000, periph_in_red});
    chk("periph_in", 16'h007F, {9'h000, periph_in});
    $display("t_route_out done");
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'h1;
    t_reset();
    t_regs();
    t_route_in();
    t_route_out();
    close_out();
  end
endmodule // rpsel_top_test
